/* File: hdl/ics_pkg.sv */
// Purpose: shared constants and types for the event acknowledge and state trigger block
// Assumes: 32-bit APB, word-aligned registers at four times their index
// Notes:   event bit positions match across status, enable and acknowledge registers
package ics_pkg;
  localparam int          ICS_DW        = 32;
  localparam int          ICS_AW        = 8;
  localparam int          ICS_EVT_N     = 20;
  // register indexes; byte address is four times the index
  localparam logic [5:0]  ICS_IDX_ENA   = 6'h01;
  localparam logic [5:0]  ICS_IDX_STAT  = 6'h02;
  localparam logic [5:0]  ICS_IDX_ACK   = 6'h03;
  localparam logic [5:0]  ICS_IDX_SETUP = 6'h04;
  localparam int          ICS_IDX_LSB   = 2;
  // event bit positions
  localparam int          ICS_B_STATE   = 5;
  localparam logic [19:0] ICS_ENA_FIXED = 20'hE0000;
  localparam logic [19:0] ICS_ENA_RW    = 20'h1FFFF;
  localparam logic [19:0] ICS_EVT_RST   = 20'h00000;
  // trigger-select field inside the transceive setup register
  localparam int          ICS_TRIG_LSB  = 4;
  localparam int          ICS_TRIG_W    = 6;
  localparam logic [5:0]  ICS_TRIG_RST  = 6'h00;
  localparam logic [31:0] ICS_ZERO      = 32'h00000000;

  typedef enum logic [2:0] {
    ICS_XS_IDLE       = 3'b000,
    ICS_XS_PRE_SEND   = 3'b001,
    ICS_XS_SENDING    = 3'b011,
    ICS_XS_PRE_RECV   = 3'b010,
    ICS_XS_DATA_WAIT  = 3'b110,
    ICS_XS_RECEIVING  = 3'b111
  } ics_xcv_state_t;

  // one-hot position of a transceive state within the trigger-select field
  function automatic logic [5:0] ics_state_bit(input ics_xcv_state_t s);
    case (s)
      ICS_XS_IDLE:      ics_state_bit = 6'h01;
      ICS_XS_PRE_SEND:  ics_state_bit = 6'h02;
      ICS_XS_SENDING:   ics_state_bit = 6'h04;
      ICS_XS_PRE_RECV:  ics_state_bit = 6'h08;
      ICS_XS_DATA_WAIT: ics_state_bit = 6'h10;
      ICS_XS_RECEIVING: ics_state_bit = 6'h20;
      default:          ics_state_bit = 6'h00;
    endcase
  endfunction
endpackage

/* File: hdl/ics_evt_if.sv */
// Purpose: carries event sets, acknowledges and latched status between modules
// Assumes: all signals on the one system clock
// Notes:   set and ack are one-cycle vectors
`timescale 1ns/1ps
`default_nettype none
interface ics_evt_if;
  logic [19:0] set;
  logic [19:0] ack;
  logic [19:0] stat;
  modport ctl (output set, output ack, input stat);
  modport lat (input set, input ack, output stat);
endinterface
`default_nettype wire

/* File: hdl/ics_event_latch.sv */
// Purpose: sticky event flags with write-one acknowledge
// Assumes: set and ack come from logic on clk
// Notes:   a set in the same cycle as its ack keeps the flag
`timescale 1ns/1ps
`default_nettype none
module ics_event_latch
  import ics_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  ics_evt_if.lat    ev
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev.stat <= ICS_EVT_RST;
    end else begin
      // set wins over ack; a zero ack bit leaves its flag alone
      ev.stat <= (ev.stat & ~ev.ack) | ev.set;
    end
  end

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    |ev.set |=> ((ev.stat & $past(ev.set)) == $past(ev.set)))
    else $error("event set lost");
  ack_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    |(ev.ack & ~ev.set) |=> ((ev.stat & $past(ev.ack & ~ev.set)) == ICS_EVT_RST))
    else $error("acknowledged flag stayed set");
endmodule
`default_nettype wire

/* File: hdl/ics_state_trigger.sv */
// Purpose: raises the state-change event on entry to an armed transceive state
// Assumes: the state input comes from logic on clk
// Notes:   leaving reset in idle does not count as an entry
`timescale 1ns/1ps
`default_nettype none
module ics_state_trigger
  import ics_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire ics_xcv_state_t state,
  input  wire logic [5:0]     sel,
  output logic                hit_q
);
  ics_xcv_state_t prev_q;
  logic           entry;

  assign entry = (state != prev_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= ICS_XS_IDLE;
    end else begin
      prev_q <= state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= 1'b0;
    end else begin
      // each select bit arms one state; several may be armed at once
      hit_q <= entry && |(ics_state_bit(state) & sel);
    end
  end

  sequence armed_entry_s;
    (state != prev_q) && |(ics_state_bit(state) & sel);
  endsequence
  armed_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
    armed_entry_s |=> hit_q)
    else $error("armed state entry missed");
  none_armed_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel == ICS_TRIG_RST) |=> !hit_q)
    else $error("event raised with nothing armed");
  idle_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ICS_XS_IDLE) && (prev_q != ICS_XS_IDLE) && !sel[0] && sel[5:1] != 5'h00 |=> !hit_q)
    else $error("idle fired without its select bit");
endmodule
`default_nettype wire

/* File: hdl/ics_top.sv */
// Purpose: APB register front of event acknowledge, status, enable and state trigger
// Assumes: event and state inputs come from logic on clk; no wait states on any access
// Notes:   irq is high while any enabled status bit is set
//
// Functional notes
// - Ack bits 19..16 clear card detect, program fail, general fault, temperature flags.
// - Ack bits 15 and 14 clear subcarrier seen and frame start seen flags.
// - Ack bits 10..6 clear field fault, own field on/off, external field on/off.
// - Ack bits 5..0 clear state, activation, scheme, idle, send, receive flags.
// - Six-bit trigger select at setup bits 9..4, read/write, resets to zero.
// - Each select bit arms one state; entry to any armed state raises event.
// - All select bits zero: the state-change event never fires.
// - Select bits 0,1,2 arm idle, pre-send wait and sending states.
// - Select bits 3,4,5 arm pre-receive wait, data wait and receiving states.
// - Events latch into status; irq high while a status bit is enabled.
// - State-change flag sits at status bit 5.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ics_top
  import ics_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ICS_AW-1:0] paddr,
  input  wire logic [ICS_DW-1:0] pwdata,
  output logic      [ICS_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [19:0]       evt_in,
  input  wire ics_xcv_state_t    xcv_state,
  output logic                   irq
);
  ics_evt_if evt ();

  logic [19:0]           ena_q;
  logic [ICS_TRIG_W-1:0] trig_sel_q;
  logic                  state_hit;
  logic                  wr_go;
  logic                  setup_go;
  logic [5:0]            idx;
  logic                  mapped;
  logic [ICS_DW-1:0]     rd_mux;

  // register index from a byte address, dropping its two low bits
  function automatic logic [5:0] word_idx(input logic [ICS_AW-1:0] a);
    word_idx = a[ICS_AW-1:ICS_IDX_LSB];
  endfunction

  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i == ICS_IDX_ENA) || (i == ICS_IDX_STAT) ||
                (i == ICS_IDX_ACK) || (i == ICS_IDX_SETUP);
  endfunction

  assign idx      = word_idx(paddr);
  assign mapped   = is_mapped(idx);
  assign setup_go = psel && !penable;
  // writes land only on the completing edge of the access phase
  assign wr_go    = psel && penable && pready && pwrite && mapped;

  ics_event_latch u_latch (
    .clk   (clk),
    .rst_n (rst_n),
    .ev    (evt.lat)
  );

  ics_state_trigger u_trig (
    .clk   (clk),
    .rst_n (rst_n),
    .state (xcv_state),
    .sel   (trig_sel_q),
    .hit_q (state_hit)
  );

  // state-change flag is fed by the trigger, not by the outside event vector
  assign evt.set = {evt_in[19:ICS_B_STATE+1], state_hit, evt_in[ICS_B_STATE-1:0]};

  // acknowledge only drops flags whose bit is one; upper bits fall outside the vector
  assign evt.ack = (wr_go && idx == ICS_IDX_ACK) ? pwdata[19:0] : ICS_EVT_RST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ena_q <= ICS_EVT_RST;
    end else if (wr_go && idx == ICS_IDX_ENA) begin
      ena_q <= pwdata[19:0] & ICS_ENA_RW;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sel_q <= ICS_TRIG_RST;
    end else if (wr_go && idx == ICS_IDX_SETUP) begin
      trig_sel_q <= pwdata[ICS_TRIG_LSB +: ICS_TRIG_W];
    end
  end

  always_comb begin
    rd_mux = ICS_ZERO;
    case (idx)
      ICS_IDX_ENA:   rd_mux[19:0] = ena_q | ICS_ENA_FIXED;
      ICS_IDX_STAT:  rd_mux[19:0] = evt.stat;
      ICS_IDX_ACK:   rd_mux = ICS_ZERO;
      ICS_IDX_SETUP: rd_mux[ICS_TRIG_LSB +: ICS_TRIG_W] = trig_sel_q;
      default:       rd_mux = ICS_ZERO;
    endcase
  end

  // no wait states: answer is registered on the setup edge, so outputs stay flopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= ICS_ZERO;
    end else begin
      pready  <= setup_go;
      pslverr <= setup_go && !mapped;
      prdata  <= (setup_go && !pwrite) ? rd_mux : ICS_ZERO;
    end
  end

  // fixed-on enables cover the three error sources that cannot be masked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt.stat & (ena_q | ICS_ENA_FIXED));
    end
  end

  sequence ack_write_s;
    psel && penable && pready && pwrite && (idx == ICS_IDX_ACK);
  endsequence

  sequence setup_write_s;
    psel && penable && pready && pwrite && (idx == ICS_IDX_SETUP);
  endsequence

  trig_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    setup_write_s |=> (trig_sel_q == $past(pwdata[ICS_TRIG_LSB +: ICS_TRIG_W])))
    else $error("trigger select not stored");
  trig_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(psel && penable && pwrite) |=> $stable(trig_sel_q))
    else $error("trigger select changed without a write");
  ack_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack_write_s ##0 (pwdata[ICS_B_STATE] && !state_hit) |=> !evt.stat[ICS_B_STATE])
    else $error("state flag not cleared");
  ack_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack_write_s ##0 (pwdata[19:0] == ICS_EVT_RST) |=> (evt.stat == ($past(evt.stat) | $past(evt.set))))
    else $error("zero acknowledge changed a flag");
  state_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_hit |=> evt.stat[ICS_B_STATE])
    else $error("state change not latched at bit five");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    |(evt.stat & (ena_q | ICS_ENA_FIXED)) |=> irq)
    else $error("enabled flag did not raise irq");
  irq_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.stat & (ena_q | ICS_ENA_FIXED)) == ICS_EVT_RST |=> !irq)
    else $error("irq without an enabled flag");
  ack_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    setup_go && !pwrite && (idx == ICS_IDX_ACK) |=> (prdata == ICS_ZERO) && pready)
    else $error("acknowledge register read not zero");
  evt_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt_in[0] |=> evt.stat[0])
    else $error("reception event not latched");
endmodule
`default_nettype wire

/* File: verification/ics_host_model.sv */
// Purpose: host side of the register bus, an APB master
// Assumes: one clk; the answer comes whenever pready is seen high
// Notes:   one idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module ics_host_model
  import ics_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // bus rests idle until the first transfer
  task automatic idle();
    psel <= 1'h0;
    penable <= 1'h0;
    pwrite <= 1'h0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // request held until pready is sampled high
    do @(posedge clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // serviced events are acknowledged before the next wait
  task automatic ack(input logic [31:0] bits);
    logic [31:0] r;
    logic        e;
    xfer(1'h1, {ICS_IDX_ACK, 2'h0}, bits, r, e);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the acknowledge and trigger block
// Assumes: bench drives inputs by NBA at the rising edge
// Notes:   register expectations follow the documented map
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ics_pkg::*;
;
  localparam logic [7:0] A_ENA = {ICS_IDX_ENA, 2'h0};
  localparam logic [7:0] A_ST  = {ICS_IDX_STAT, 2'h0};
  localparam logic [7:0] A_SU  = {ICS_IDX_SETUP, 2'h0};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [19:0] evt_in;
  ics_xcv_state_t xcv_state;
  ics_xcv_state_t st [6] = '{ICS_XS_IDLE, ICS_XS_PRE_SEND, ICS_XS_SENDING,
                             ICS_XS_PRE_RECV, ICS_XS_DATA_WAIT, ICS_XS_RECEIVING};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  ics_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_in(evt_in), .xcv_state(xcv_state), .irq(irq));
  ics_host_model u_host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the tests take
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_host.xfer(1'h1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    u_host.xfer(1'h0, a, 32'h00000000, r, e);
    chk_reg(r, x);
    chk_bit(e, xe);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_reset();
    rd(A_SU, 32'h00000000, 1'h0);
    rd(A_ENA, 32'h000E0000, 1'h0);
    rd(A_ST, 32'h00000000, 1'h0);
    rd({ICS_IDX_ACK, 2'h0}, 32'h00000000, 1'h0);
    rd(8'hFC, 32'h00000000, 1'h1);
  endtask
  task automatic t_events();
    @(posedge clk);
    evt_in <= 20'hFFFFF;
    @(posedge clk);
    evt_in <= 20'h00000;
    wait_n(3);
    chk_bit(irq, 1'h1);
    rd(A_ST, 32'h000FFFDF, 1'h0);
    u_host.ack(32'hFFF00000);
    rd(A_ST, 32'h000FFFDF, 1'h0);
    u_host.ack(32'h000F0000);
    rd(A_ST, 32'h0000FFDF, 1'h0);
    chk_bit(irq, 1'h0);
    u_host.ack(32'h0000C000);
    rd(A_ST, 32'h00003FDF, 1'h0);
    u_host.ack(32'h00003800);
    rd(A_ST, 32'h000007DF, 1'h0);
    u_host.ack(32'h000007C0);
    rd(A_ST, 32'h0000001F, 1'h0);
    u_host.ack(32'h0000001F);
    rd(A_ST, 32'h00000000, 1'h0);
  endtask
  task automatic t_mask();
    wr(A_ENA, 32'hFFFFFFC1);
    rd(A_ENA, 32'h000FFFC1, 1'h0);
    wr(A_ENA, 32'h00000001);
    @(posedge clk);
    evt_in <= 20'h00001;
    @(posedge clk);
    evt_in <= 20'h00000;
    wait_n(3);
    chk_bit(irq, 1'h1);
    wr(A_ENA, 32'h00000000);
    wait_n(2);
    chk_bit(irq, 1'h0);
    wr(A_ENA, 32'h00000001);
    wait_n(2);
    chk_bit(irq, 1'h1);
    u_host.ack(32'h00000001);
    wait_n(2);
    chk_bit(irq, 1'h0);
  endtask
  task automatic step(input ics_xcv_state_t s, input logic [31:0] x);
    @(posedge clk);
    xcv_state <= s;
    wait_n(4);
    rd(A_ST, x, 1'h0);
  endtask
  task automatic t_trig();
    logic [31:0] v;
    wr(A_ENA, 32'h00000020);
    for (int i = 0; i < 6; i++) begin
      v = {22'h000000, 6'h01 << i, 4'h0};
      wr(A_SU, v | 32'hFFFFFC0F);
      rd(A_SU, v, 1'h0);
      step(st[(i + 1) % 6], 32'h00000000);
      step(st[i], 32'h00000020);
      chk_bit(irq, 1'h1);
      u_host.ack(32'h00000020);
      rd(A_ST, 32'h00000000, 1'h0);
    end
    wr(A_SU, 32'h00000000);
    for (int i = 5; i >= 0; i--)
      step(st[i], 32'h00000000);
    wr(A_SU, 32'h00000280);
    step(ICS_XS_PRE_RECV, 32'h00000020);
    u_host.ack(32'h00000020);
    step(ICS_XS_RECEIVING, 32'h00000020);
  endtask
  // mid-run reset must bring select, enable and status back to rest
  task automatic t_rst();
    wr(A_SU, 32'h000003F0);
    wr(A_ENA, 32'h0001FFFF);
    @(posedge clk);
    evt_in <= 20'h00001;
    @(posedge clk);
    evt_in <= 20'h00000;
    rst_n <= 1'h0;
    wait_n(2);
    chk_bit(irq, 1'h0);
    rst_n <= 1'h1;
    rd(A_SU, 32'h00000000, 1'h0);
    rd(A_ENA, 32'h000E0000, 1'h0);
    rd(A_ST, 32'h00000000, 1'h0);
  endtask
  initial begin
    u_host.idle();
    evt_in <= 20'h00000;
    xcv_state <= ICS_XS_IDLE;
    wait_n(16);
    rst_n <= 1'h1;
    t_reset();
    t_events();
    t_mask();
    t_trig();
    t_rst();
    stop_test();
  end
endmodule
`default_nettype wire
